// ---- srf_refresh_core.sv ----
`timescale 1ns/1ns
module srf_refresh_core (
    input  wire logic                            clock_i,
    input  wire logic                            rst_b_i,
    input  wire logic                            cke_i,
    input  wire logic                            cs_b_i,
    input  wire logic                            ras_b_i,
    input  wire logic                            cas_b_i,
    input  wire logic                            we_b_i,
    input  wire logic [srf_pkg::ADDR_WIDTH-1:0]  addr_i,
    input  wire logic                            dll_enable_mode_i,
    output logic      [srf_pkg::ROW_WIDTH-1:0]   refresh_row_o,
    output logic                                 refresh_active_o,
    output logic                                 banks_idle_o,
    output logic                                 self_refresh_o,
    output logic                                 int_clock_en_o,
    output logic                                 controls_accepted_o,
    output logic                                 dll_on_o,
    output logic                                 dll_reset_o
);
    import srf_pkg::*;

    // ****************************************
    // Command decode
    // ****************************************
    function automatic logic is_ref_pattern(input logic cs_b, input logic ras_b,
                                            input logic cas_b, input logic we_b);
        is_ref_pattern = !cs_b && !ras_b && !cas_b && we_b;
    endfunction

    srf_state_type              state_reg;
    srf_state_type              state_next;
    logic [BUSY_WIDTH-1:0]      busy_reg;
    logic [BUSY_WIDTH-1:0]      busy_next;
    logic [TIMER_WIDTH-1:0]     timer_reg;
    logic [TIMER_WIDTH-1:0]     timer_next;
    logic [ROW_WIDTH-1:0]       row_reg;
    logic [ROW_WIDTH-1:0]       row_next;
    logic                       cke_prev_reg;
    logic                       cke_prev_next;
    logic                       dll_on_reg;
    logic                       dll_on_next;
    logic                       dll_reset_reg;
    logic                       dll_reset_next;
    logic                       active_reg;
    logic                       active_next;
    logic                       ref_cmd;
    logic                       sre_cmd;
    logic                       srx_cmd;
    logic                       int_start;
    logic                       ext_start;
    logic                       addr_unused;

    // Address is never used: rows come from the internal counter
    assign addr_unused = ^addr_i;

    assign ref_cmd   = cke_prev_reg && cke_i &&
                       is_ref_pattern(cs_b_i, ras_b_i, cas_b_i, we_b_i);
    assign sre_cmd   = cke_prev_reg && !cke_i &&
                       is_ref_pattern(cs_b_i, ras_b_i, cas_b_i, we_b_i);
    assign srx_cmd   = (state_reg == SRF_SELF) && cke_i;
    assign ext_start = (state_reg == SRF_IDLE) && ref_cmd && (busy_reg == BUSY_RESET);
    assign int_start = (state_reg == SRF_SELF) && (timer_reg == TIMER_RESET) &&
                       (busy_reg == BUSY_RESET);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_next     = state_reg;
        busy_next      = busy_reg;
        timer_next     = timer_reg;
        row_next       = row_reg;
        cke_prev_next  = cke_i;
        dll_on_next    = dll_on_reg;
        dll_reset_next = 1'b0;

        // Refresh cycle countdown, also finishes across exit
        if (busy_reg != BUSY_RESET) begin
            busy_next = busy_reg - 4'h1;
        end

        case (state_reg)
            SRF_IDLE: begin
                dll_on_next = dll_enable_mode_i;
                if (ext_start) begin
                    row_next   = row_reg + 13'h0001;
                    busy_next  = BUSY_LOAD;
                    state_next = SRF_REFRESH;
                end else if (sre_cmd) begin
                    dll_on_next = 1'b0;
                    timer_next  = TIMER_RESET;
                    state_next  = SRF_SELF;
                end
            end
            SRF_REFRESH: begin
                dll_on_next = dll_enable_mode_i;
                if (busy_reg == 4'h1) begin
                    state_next = SRF_IDLE;
                end
            end
            SRF_SELF: begin
                if (int_start) begin
                    row_next   = row_reg + 13'h0001;
                    busy_next  = BUSY_LOAD;
                    timer_next = TIMER_LOAD;
                end else if (timer_reg != TIMER_RESET) begin
                    timer_next = timer_reg - 9'h001;
                end
                if (srx_cmd) begin
                    dll_on_next    = dll_enable_mode_i;
                    dll_reset_next = dll_enable_mode_i;
                    state_next     = SRF_IDLE;
                end
            end
            default: begin
                state_next = SRF_IDLE;
            end
        endcase

        active_next = (busy_next != BUSY_RESET);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            state_reg     <= SRF_IDLE;
            busy_reg      <= BUSY_RESET;
            timer_reg     <= TIMER_RESET;
            row_reg       <= ROW_RESET;
            cke_prev_reg  <= 1'b0;
            dll_on_reg    <= 1'b0;
            dll_reset_reg <= 1'b0;
            active_reg    <= 1'b0;
        end else begin
            state_reg     <= state_next;
            busy_reg      <= busy_next;
            timer_reg     <= timer_next;
            row_reg       <= row_next;
            cke_prev_reg  <= cke_prev_next;
            dll_on_reg    <= dll_on_next;
            dll_reset_reg <= dll_reset_next;
            active_reg    <= active_next;
        end
    end

    assign refresh_row_o       = row_reg;
    assign refresh_active_o    = active_reg;
    assign banks_idle_o        = !active_reg;
    assign self_refresh_o      = (state_reg == SRF_SELF);
    assign int_clock_en_o      = (state_reg != SRF_SELF);
    assign controls_accepted_o = (state_reg != SRF_SELF);
    assign dll_on_o            = dll_on_reg;
    assign dll_reset_o         = dll_reset_reg;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_refresh_run;
        refresh_active_o [*6] ##1 banks_idle_o;
    endsequence

    property p_row_from_counter;
        ext_start |=> (refresh_row_o == $past(refresh_row_o) + 13'h0001);
    endproperty
    a_row_from_counter: assert property (p_row_from_counter)
        else $error("refresh row not taken from internal counter");

    property p_idle_after_refresh;
        ext_start |=> s_refresh_run;
    endproperty
    a_idle_after_refresh: assert property (p_idle_after_refresh)
        else $error("banks not idle after refresh cycle");

    sequence s_entry_dll;
        sre_cmd && (state_reg == SRF_IDLE) && !ext_start;
    endsequence

    property p_dll_off_entry;
        s_entry_dll |=> !dll_on_o && self_refresh_o;
    endproperty
    a_dll_off_entry: assert property (p_dll_off_entry)
        else $error("DLL not disabled on self-refresh entry");

    property p_dll_reset_exit;
        srx_cmd && dll_enable_mode_i |=> dll_on_o && dll_reset_o ##1 !dll_reset_o;
    endproperty
    a_dll_reset_exit: assert property (p_dll_reset_exit)
        else $error("DLL not re-enabled with reset on exit");

    property p_clock_gated;
        self_refresh_o && !cke_i |=> self_refresh_o && !int_clock_en_o && !controls_accepted_o;
    endproperty
    a_clock_gated: assert property (p_clock_gated)
        else $error("internal clock running in self-refresh");

    property p_internal_refresh;
        s_entry_dll ##1 !cke_i [*3] |-> ##[0:3] (refresh_active_o && self_refresh_o);
    endproperty
    a_internal_refresh: assert property (p_internal_refresh)
        else $error("no internal refresh within minimum clock-enable pulse");

    property p_ignore_commands;
        self_refresh_o && !cke_i |=> $stable(refresh_row_o) || $rose(refresh_active_o);
    endproperty
    a_ignore_commands: assert property (p_ignore_commands)
        else $error("row counter moved without internal refresh");

endmodule

// ---- srf_pkg.sv ----
package srf_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLOCK_PERIOD_NS        = 20;
    localparam int REFRESH_CYCLE_NS       = 110;
    localparam int REFRESH_CYCLES         =
        (REFRESH_CYCLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int CKE_MIN_PULSE_NS       = 60;
    localparam int CKE_MIN_CYCLES         =
        (CKE_MIN_PULSE_NS / CLOCK_PERIOD_NS) < 1 ? 1 : CKE_MIN_PULSE_NS / CLOCK_PERIOD_NS;
    localparam int SR_REFRESH_INTERVAL_NS = 7800;
    localparam int SR_REFRESH_CYCLES      = SR_REFRESH_INTERVAL_NS / CLOCK_PERIOD_NS;

    // ****************************************
    // Widths and reset values
    // ****************************************
    localparam int ADDR_WIDTH  = 16;
    localparam int ROW_WIDTH   = 13;
    localparam int BUSY_WIDTH  = 4;
    localparam int TIMER_WIDTH = 9;
    localparam logic [ROW_WIDTH-1:0]   ROW_RESET   = 13'h0000;
    localparam logic [BUSY_WIDTH-1:0]  BUSY_RESET  = 4'h0;
    localparam logic [BUSY_WIDTH-1:0]  BUSY_LOAD   = BUSY_WIDTH'(REFRESH_CYCLES);
    localparam logic [TIMER_WIDTH-1:0] TIMER_RESET = 9'h000;
    localparam logic [TIMER_WIDTH-1:0] TIMER_LOAD  = TIMER_WIDTH'(SR_REFRESH_CYCLES - 1);

    typedef enum logic [1:0] {
        SRF_IDLE,
        SRF_REFRESH,
        SRF_SELF
    } srf_state_type;

endpackage

// ---- srf_ctrl_model.sv ----
`timescale 1ns/1ns
module srf_ctrl_model (
    input  wire logic                           clock_i,
    output logic                                cke_o,
    output logic                                cs_b_o,
    output logic                                ras_b_o,
    output logic                                cas_b_o,
    output logic                                we_b_o,
    output logic [srf_pkg::ADDR_WIDTH-1:0]      addr_o
);
    import srf_pkg::*;
    initial begin
        cke_o = 1'b1;
        cs_b_o = 1'b0;
        ras_b_o = 1'b1;
        cas_b_o = 1'b1;
        we_b_o = 1'b1;
        addr_o = 16'h0000;
    end
    always @(posedge clock_i) begin
        addr_o <= addr_o + 16'h1235;
    end
    // only refresh or NOP, never a write
    task automatic send(input logic cke_v, input logic refr);
        @(posedge clock_i);
        cke_o <= cke_v;
        ras_b_o <= ~refr;
        cas_b_o <= ~refr;
        @(posedge clock_i);
        ras_b_o <= 1'b1;
        cas_b_o <= 1'b1;
    endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ns
module testbench;
    import srf_pkg::*;
    logic                 clock_i = 1'b0;
    logic                 rst_b_i = 1'b0;
    logic                 dll_mode = 1'b1;
    logic                 cke, cs_b, ras_b, cas_b, we_b;
    logic [ADDR_WIDTH-1:0] addr;
    logic [ROW_WIDTH-1:0] row, row_exp;
    logic                 act, idle, self, clk_en, acc, dll_on, dll_rst;
    int                   miscompares = 0;
    int                   checks = 0;
    int                   cycles = 0;
    wire logic [6:0]      flags = {act, idle, self, clk_en, acc, dll_on, dll_rst};

    always #10 clock_i = ~clock_i;

    srf_ctrl_model srf_ctrl_model_i (.clock_i(clock_i), .cke_o(cke), .cs_b_o(cs_b),
        .ras_b_o(ras_b), .cas_b_o(cas_b), .we_b_o(we_b), .addr_o(addr));
    srf_refresh_core srf_refresh_core_i (.clock_i(clock_i), .rst_b_i(rst_b_i), .cke_i(cke),
        .cs_b_i(cs_b), .ras_b_i(ras_b), .cas_b_i(cas_b), .we_b_i(we_b), .addr_i(addr),
        .dll_enable_mode_i(dll_mode), .refresh_row_o(row), .refresh_active_o(act),
        .banks_idle_o(idle), .self_refresh_o(self), .int_clock_en_o(clk_en),
        .controls_accepted_o(acc), .dll_on_o(dll_on), .dll_reset_o(dll_rst));

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run;
        if (miscompares == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            complete_run();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_refresh;
        srf_ctrl_model_i.send(1'b1, 1'b1);
        step(1);
        row_exp = row_exp + 13'h0001;
        check("row", 16'(row), 16'(row_exp));
        check("flags", 16'(flags), 16'h004e);
        srf_ctrl_model_i.send(1'b1, 1'b0);
        step(2);
        check("flags", 16'(flags), 16'h004e);
        step(1);
        check("flags", 16'(flags), 16'h002e);
        check("row", 16'(row), 16'(row_exp));
    endtask
    task automatic test_self(input logic mode);
        @(posedge clock_i);
        dll_mode <= mode;
        srf_ctrl_model_i.send(1'b0, 1'b1);
        step(0);
        check("flags", 16'(flags), 16'h0030);
        step(1);
        row_exp = row_exp + 13'h0001;
        check("flags", 16'(flags), 16'h0050);
        check("row", 16'(row), 16'(row_exp));
        srf_ctrl_model_i.send(1'b0, 1'b1);
        step(376);
        check("row", 16'(row), 16'(row_exp));
        step(20);
        row_exp = row_exp + 13'h0001;
        check("row", 16'(row), 16'(row_exp));
        srf_ctrl_model_i.send(1'b1, 1'b0);
        step(0);
        check("flags", 16'(flags), 16'({5'b01011, mode, mode}));
        step(1);
        check("dll_reset", 16'(dll_rst), 16'h0000);
    endtask

    initial begin
        row_exp = ROW_RESET;
        step(3);
        check("reset_flags", 16'(flags), 16'h002c);
        check("reset_row", 16'(row), 16'(row_exp));
        @(posedge clock_i);
        rst_b_i <= 1'b1;
        step(3);
        test_refresh();
        test_self(1'b1);
        step(REFRESH_CYCLES);
        test_refresh();
        test_self(1'b0);
        complete_run();
    end
endmodule
